// *** design/acc_pkg.sv ***
// Shared constants and types for the converter control block
package acc_pkg;

	// Bus geometry
	localparam int             ACC_ADDR_W      = 8;
	localparam logic [1:0]     ACC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]     ACC_RESP_SLVERR = 2'h2;

	// Register byte offsets
	localparam logic [7:0]     ACC_OFF_CTRL0   = 8'h00;
	localparam logic [7:0]     ACC_OFF_CLKCFG  = 8'h04;
	localparam logic [7:0]     ACC_OFF_RES_HI  = 8'h08;
	localparam logic [7:0]     ACC_OFF_RES_LO  = 8'h0C;
	localparam logic [7:0]     ACC_OFF_IRQ_ST  = 8'h10;
	localparam logic [7:0]     ACC_OFF_IRQ_MSK = 8'h14;

	// Field positions, control register zero
	localparam int             ACC_C0_JUSTIFY  = 7;
	localparam int             ACC_C0_REF      = 6;
	localparam int             ACC_C0_CHAN_HI  = 5;
	localparam int             ACC_C0_CHAN_LO  = 2;
	localparam int             ACC_C0_GO       = 1;
	localparam int             ACC_C0_POWER    = 0;

	// Field positions, clock configuration register
	localparam int             ACC_C1_CLK_HI   = 6;
	localparam int             ACC_C1_CLK_LO   = 4;

	// Reset values of the control registers
	localparam logic [7:0]     ACC_CTRL0_RST   = 8'h00;
	localparam logic [2:0]     ACC_CLKSEL_RST  = 3'h0;

	// Result layout
	localparam int             ACC_RES_W       = 10;
	localparam logic [9:0]     ACC_TRIAL_MSB   = 10'h200;

	// Conversion timing in bit periods
	localparam int             ACC_PERIOD_W    = 4;
	localparam int             ACC_CONV_PERIODS  = 11;
	localparam int             ACC_ABORT_PERIODS = 2;

	// Clock selection codes and divide ratios
	localparam int             ACC_DIV_W       = 7;
	localparam logic [2:0]     ACC_CLK_DIV2    = 3'h0;
	localparam logic [2:0]     ACC_CLK_DIV8    = 3'h1;
	localparam logic [2:0]     ACC_CLK_DIV32   = 3'h2;
	localparam logic [2:0]     ACC_CLK_DIV4    = 3'h4;
	localparam logic [2:0]     ACC_CLK_DIV16   = 3'h5;
	localparam logic [2:0]     ACC_CLK_DIV64   = 3'h6;
	localparam logic [1:0]     ACC_CLK_RC_LOW  = 2'h3;
	localparam int             ACC_SYS_CLK_KHZ = 10000;
	localparam int             ACC_RC_MAX_KHZ  = 500;
	// Fastest allowed internal clock: divide rounded up
	localparam logic [6:0]     ACC_RC_DIV      = 7'((ACC_SYS_CLK_KHZ + ACC_RC_MAX_KHZ - 1) / ACC_RC_MAX_KHZ);

	// Interrupt bit
	localparam int             ACC_IRQ_DONE    = 0;

	typedef enum logic [2:0] {
		ACC_ST_IDLE  = 3'h1,
		ACC_ST_CONV  = 3'h2,
		ACC_ST_ABORT = 3'h4
	} acc_state_type;

endpackage

// *** design/acc_bit_clock.sv ***
// Conversion bit-period tick generator
module acc_bit_clock (
	// Clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// Control
	input  wire logic                         restart,
	input  wire logic [2:0]                   clk_sel,
	// Tick at end of each bit period
	output logic                              tick
);
	import acc_pkg::*;

	logic [ACC_DIV_W-1:0] cnt_q;
	logic [ACC_DIV_W-1:0] cnt_d;
	logic [ACC_DIV_W-1:0] div;
	wire                  rc_sel = (clk_sel[1:0] == ACC_CLK_RC_LOW);

	// Internal oscillator modelled as the divide that keeps it at or under its ceiling
	// Divide by 2 is shorter than the comparator synchroniser delay, so results there are unreliable
	assign div = rc_sel                   ? ACC_RC_DIV :
	             (clk_sel == ACC_CLK_DIV2)  ? 7'h02 :
	             (clk_sel == ACC_CLK_DIV8)  ? 7'h08 :
	             (clk_sel == ACC_CLK_DIV32) ? 7'h20 :
	             (clk_sel == ACC_CLK_DIV4)  ? 7'h04 :
	             (clk_sel == ACC_CLK_DIV16) ? 7'h10 : 7'h40;

	assign tick  = !restart && (cnt_q == div - 7'h01);
	assign cnt_d = (restart || tick) ? '0 : cnt_q + 7'h01;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule

// *** design/acc_conv_ctrl.sv ***
// Converter control: AXI4-Lite registers, sequencing and successive approximation
// Operation
// - Control zero bit 7 set gives right-justified result, clear gives left-justified.
// - Control zero bit 6 picks external reference pin when 1, supply when 0.
// - Channel field bits 5-2: codes 0-11 inputs, 12 comparator reference, 13 fixed 0.6 V.
// - Writing go bit 1 starts conversion; it reads 1 while conversion runs.
// - Hardware clears go when conversion finishes; 0 means done or idle.
// - Power bit 0 enables converter; when clear converter is off.
// - Clock field bits 6-4 divide system clock 2,8,32,4,16,64; x11 selects internal oscillator.
// - Internal conversion oscillator runs no faster than 500 kHz.
// - Clock register holds only its clock field; bit 7 and bits 3-0 read zero.
// - Left justified: high holds result 9-2, low bits 7-6 hold result 1-0.
// - Right justified: high bits 1-0 hold result 9-8, low holds result 7-0.
// - A full conversion lasts eleven bit periods from start to completion.
// - At completion clear go, set done flag regardless of mask, load result registers.
// - Go cleared early keeps old result, waits two bit periods, then acquisition resumes.
// - Special event trigger sets go in hardware and starts a conversion.
//
// Our own choices: the AXI4-Lite register port and the address map.
module acc_conv_ctrl (
	// Clock and reset
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	// AXI4-Lite write address
	input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [acc_pkg::ACC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// Interrupt
	output logic                                irq,
	// Trigger from capture/compare unit, same clock
	input  wire logic                           special_event_trig,
	// Analog front end
	output logic [3:0]                          input_channel_sel,
	output logic                                pos_reference_sel,
	output logic                                converter_power_on,
	output logic                                ana_sample,
	output logic [acc_pkg::ACC_RES_W-1:0]       ana_trial_code,
	input  wire logic                           ana_cmp_above
);
	import acc_pkg::*;

	// Bus state
	logic                  aw_hold_q;
	logic [ACC_ADDR_W-1:0] awaddr_q;
	logic                  w_hold_q;
	logic [7:0]            wdata_q;
	logic                  wstrb0_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [7:0]            rdata_q;

	// Control and status
	logic                  justify_q;
	logic                  ref_q;
	logic [3:0]            chan_q;
	logic                  power_q;
	logic [2:0]            clk_sel_q;
	logic [7:0]            res_hi_q;
	logic [7:0]            res_lo_q;
	logic                  done_flag_q;
	logic                  done_mask_q;
	acc_state_type         state_q;
	acc_state_type         state_d;
	logic [ACC_PERIOD_W-1:0] period_q;
	logic [ACC_RES_W-1:0]  trial_q;
	logic [ACC_RES_W-1:0]  mask_q;
	logic                  cmp_meta_q;
	logic                  cmp_sync_q;

	// Bus decode
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire  = s_axi_wvalid && s_axi_wready;
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	wire wr_lane = wr_fire && wstrb0_q;
	wire wr_ctrl0  = wr_lane && (awaddr_q == ACC_OFF_CTRL0);
	wire wr_clkcfg = wr_lane && (awaddr_q == ACC_OFF_CLKCFG);
	wire wr_res_hi = wr_lane && (awaddr_q == ACC_OFF_RES_HI);
	wire wr_res_lo = wr_lane && (awaddr_q == ACC_OFF_RES_LO);
	wire wr_mask   = wr_lane && (awaddr_q == ACC_OFF_IRQ_MSK);
	wire wr_mapped = (awaddr_q == ACC_OFF_CTRL0) || (awaddr_q == ACC_OFF_CLKCFG) ||
	                 (awaddr_q == ACC_OFF_RES_HI) || (awaddr_q == ACC_OFF_RES_LO) ||
	                 (awaddr_q == ACC_OFF_IRQ_ST) || (awaddr_q == ACC_OFF_IRQ_MSK);
	wire rd_mapped = (s_axi_araddr == ACC_OFF_CTRL0) || (s_axi_araddr == ACC_OFF_CLKCFG) ||
	                 (s_axi_araddr == ACC_OFF_RES_HI) || (s_axi_araddr == ACC_OFF_RES_LO) ||
	                 (s_axi_araddr == ACC_OFF_IRQ_ST) || (s_axi_araddr == ACC_OFF_IRQ_MSK);
	wire rd_status = ar_fire && (s_axi_araddr == ACC_OFF_IRQ_ST);

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = {24'h00_0000, rdata_q};

	// Sequencer decode
	wire go_bit   = (state_q == ACC_ST_CONV);
	wire tick;
	wire in_conv  = (state_q == ACC_ST_CONV);
	wire in_abort = (state_q == ACC_ST_ABORT);
	wire idle     = (state_q == ACC_ST_IDLE);
	// A start needs the converter already powered; go is dropped otherwise
	wire start    = idle && power_q &&
	                ((wr_ctrl0 && wdata_q[ACC_C0_GO]) || special_event_trig);
	wire sw_abort = in_conv && wr_ctrl0 && !wdata_q[ACC_C0_GO];
	wire pwr_kill = !power_q && !idle;
	wire decide   = in_conv && tick && (period_q != '0);
	wire done     = in_conv && tick && (period_q == 4'(ACC_CONV_PERIODS - 1));
	wire abort_end = in_abort && tick && (period_q == 4'(ACC_ABORT_PERIODS - 1));
	wire restart  = start || sw_abort;

	// Successive approximation step: drop the trial bit if the input is below it
	wire [ACC_RES_W-1:0] trial_next = (cmp_sync_q ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);

	// Result formatting
	wire [7:0] fmt_hi = justify_q ? {6'h00, trial_next[9:8]} : trial_next[9:2];
	wire [7:0] fmt_lo = justify_q ? trial_next[7:0] : {trial_next[1:0], 6'h00};

	// Read mux
	wire [7:0] ctrl0_rd = {justify_q, ref_q, chan_q, go_bit, power_q};
	wire [7:0] clkcfg_rd = {1'h0, clk_sel_q, 4'h0};
	wire [7:0] rd_mux = (s_axi_araddr == ACC_OFF_CTRL0)   ? ctrl0_rd :
	                    (s_axi_araddr == ACC_OFF_CLKCFG)  ? clkcfg_rd :
	                    (s_axi_araddr == ACC_OFF_RES_HI)  ? res_hi_q :
	                    (s_axi_araddr == ACC_OFF_RES_LO)  ? res_lo_q :
	                    (s_axi_araddr == ACC_OFF_IRQ_ST)  ? {7'h00, done_flag_q} :
	                    (s_axi_araddr == ACC_OFF_IRQ_MSK) ? {7'h00, done_mask_q} : 8'h00;

	assign irq                = done_flag_q && done_mask_q;
	assign input_channel_sel  = chan_q;
	assign pos_reference_sel  = ref_q;
	assign converter_power_on = power_q;
	// Sampling resumes on its own once the abort wait is over
	assign ana_sample         = power_q && idle;
	assign ana_trial_code     = trial_q;

	acc_bit_clock u_bit_clock (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (restart),
		.clk_sel (clk_sel_q),
		.tick    (tick)
	);

	// Write channel capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'h0;
			awaddr_q  <= '0;
			w_hold_q  <= 1'h0;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'h0;
		end else begin
			if (aw_fire) begin
				aw_hold_q <= 1'h1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'h0;
			end
			if (w_fire) begin
				w_hold_q <= 1'h1;
				wdata_q  <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_hold_q <= 1'h0;
			end
		end
	end

	// Responses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'h0;
			bresp_q  <= ACC_RESP_OKAY;
			rvalid_q <= 1'h0;
			rresp_q  <= ACC_RESP_OKAY;
			rdata_q  <= 8'h00;
		end else begin
			if (wr_fire) begin
				bvalid_q <= 1'h1;
				bresp_q  <= wr_mapped ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'h0;
			end
			if (ar_fire) begin
				rvalid_q <= 1'h1;
				rresp_q  <= rd_mapped ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
				rdata_q  <= rd_mux;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'h0;
			end
		end
	end

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{justify_q, ref_q, chan_q} <= ACC_CTRL0_RST[ACC_C0_JUSTIFY:ACC_C0_CHAN_LO];
			power_q     <= ACC_CTRL0_RST[ACC_C0_POWER];
			clk_sel_q   <= ACC_CLKSEL_RST;
			done_mask_q <= 1'h0;
		end else begin
			if (wr_ctrl0) begin
				{justify_q, ref_q, chan_q} <= wdata_q[ACC_C0_JUSTIFY:ACC_C0_CHAN_LO];
				power_q <= wdata_q[ACC_C0_POWER];
			end
			if (wr_clkcfg)
				clk_sel_q <= wdata_q[ACC_C1_CLK_HI:ACC_C1_CLK_LO];
			if (wr_mask)
				done_mask_q <= wdata_q[ACC_IRQ_DONE];
		end
	end

	// Done flag: a completion in the same cycle as a clearing read wins
	always_ff @(posedge aclk) begin
		if (!aresetn)
			done_flag_q <= 1'h0;
		else if (done)
			done_flag_q <= 1'h1;
		else if (rd_status)
			done_flag_q <= 1'h0;
	end

	// Result registers keep their contents through reset
	always_ff @(posedge aclk) begin
		if (done) begin
			res_hi_q <= fmt_hi;
			res_lo_q <= fmt_lo;
		end else begin
			if (wr_res_hi)
				res_hi_q <= wdata_q;
			if (wr_res_lo)
				res_lo_q <= wdata_q;
		end
	end

	// Comparator comes from the analog domain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_meta_q <= 1'h0;
			cmp_sync_q <= 1'h0;
		end else begin
			cmp_meta_q <= ana_cmp_above;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ACC_ST_IDLE: begin
				if (start)
					state_d = ACC_ST_CONV;
			end
			ACC_ST_CONV: begin
				if (pwr_kill || done)
					state_d = ACC_ST_IDLE;
				else if (sw_abort)
					state_d = ACC_ST_ABORT;
			end
			ACC_ST_ABORT: begin
				if (pwr_kill || abort_end)
					state_d = ACC_ST_IDLE;
			end
			default: state_d = ACC_ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_q <= ACC_ST_IDLE;
		else
			state_q <= state_d;
	end

	// Bit-period counter and approximation register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_q <= '0;
			trial_q  <= '0;
			mask_q   <= '0;
		end else if (restart) begin
			period_q <= '0;
			if (start) begin
				trial_q <= ACC_TRIAL_MSB;
				mask_q  <= ACC_TRIAL_MSB;
			end
		end else if (tick && !idle) begin
			period_q <= period_q + 4'h1;
			if (decide) begin
				trial_q <= trial_next;
				mask_q  <= mask_q >> 1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [ACC_PERIOD_W-1:0] chk_ticks_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || start)
			chk_ticks_q <= '0;
		else if (in_conv && tick)
			chk_ticks_q <= chk_ticks_q + 4'h1;
	end
	a_conv_eleven_periods:
		assert property (in_conv && tick && chk_ticks_q == 4'(ACC_CONV_PERIODS - 1) |-> done)
		else $error("conversion did not end on eleventh bit period");
	a_done_not_early:
		assert property (done |-> chk_ticks_q == 4'(ACC_CONV_PERIODS - 1))
		else $error("conversion ended early");
	a_go_reads_busy:
		assert property (start |=> ctrl0_rd[ACC_C0_GO] && in_conv)
		else $error("go bit not set after start");
	a_go_auto_clear:
		assert property (done |=> !ctrl0_rd[ACC_C0_GO] && idle)
		else $error("go bit not cleared at completion");
	a_done_flag_set:
		assert property (done |=> done_flag_q && res_hi_q == $past(fmt_hi) && res_lo_q == $past(fmt_lo))
		else $error("completion did not set flag and load result");
	a_abort_keeps_res:
		assert property (sw_abort && wdata_q[ACC_C0_POWER] |=> (in_abort && $stable(res_hi_q) && $stable(res_lo_q))[*2])
		else $error("result changed after abort");
	a_abort_resamples:
		assert property (abort_end && power_q |=> ana_sample)
		else $error("sampling not resumed after abort wait");
	a_no_start_off:
		assert property (!power_q && idle |=> idle)
		else $error("conversion started with converter off");
	a_trigger_starts:
		assert property (special_event_trig && idle && power_q |=> in_conv)
		else $error("special event trigger did not start conversion");
	a_clkcfg_zeros:
		assert property (ar_fire && s_axi_araddr == ACC_OFF_CLKCFG |=> s_axi_rdata[7] == 1'h0 && s_axi_rdata[3:0] == 4'h0)
		else $error("clock register unimplemented bits read nonzero");
	a_right_justify:
		assert property (done && justify_q |=> res_hi_q[7:2] == 6'h00 && res_lo_q == $past(trial_next[7:0]))
		else $error("right justified layout wrong");
	a_left_justify:
		assert property (done && !justify_q |=> res_hi_q == $past(trial_next[9:2]) && res_lo_q[5:0] == 6'h00)
		else $error("left justified layout wrong");

endmodule

// *** verification/acc_analog_model.sv ***
// Analog front end model: channel levels and comparator
module acc_analog_model (
	// Clock
	input  wire logic       aclk,
	// Selection from the converter
	input  wire logic [3:0] input_channel_sel,
	input  wire logic       pos_reference_sel,
	input  wire logic       converter_power_on,
	input  wire logic [9:0] ana_trial_code,
	// Comparator back to the converter
	output logic            ana_cmp_above
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [9:0] level;
	logic       toggle_q = 1'b0;

	// Each channel and reference pairing gets its own level
	assign level = {input_channel_sel, pos_reference_sel, 5'h15};

	// Unpowered comparator output is noise, never a stable last value
	always @(posedge aclk) toggle_q <= ~toggle_q;
	assign ana_cmp_above = converter_power_on ? (level >= ana_trial_code) : toggle_q;
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the converter control block
module tb import acc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, trig, ref_sel, pwr, sample, cmp;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, hi0, lo0;
	logic [3:0]  wstrb, ch_sel;
	logic [1:0]  bresp, rresp, last_resp;
	logic [9:0]  trial;
	int          err_total, check_count, cyc, busy_cyc;

	acc_conv_ctrl u_acc_conv_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .special_event_trig(trig),
		.input_channel_sel(ch_sel), .pos_reference_sel(ref_sel), .converter_power_on(pwr), .ana_sample(sample),
		.ana_trial_code(trial), .ana_cmp_above(cmp));

	acc_analog_model u_acc_analog_model (.aclk(aclk), .input_channel_sel(ch_sel), .pos_reference_sel(ref_sel),
		.converter_power_on(pwr), .ana_trial_code(trial), .ana_cmp_above(cmp));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Low time of the sample strobe while powered measures a conversion or abort wait
	always @(posedge aclk) begin
		cyc++;
		if (pwr === 1'b1 && sample === 1'b0) busy_cyc++;
		if (cyc == 60000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [7:0] v);
		awaddr <= a;
		wdata <= {24'h00_0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				last_resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			else if (rvalid && rready) begin
				v = rdata;
				last_resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		axr(a, v);
		chk(v, exp);
	endtask

	function automatic int divof(input logic [2:0] c);
		case (c)
			3'h0: return 2;
			3'h1: return 8;
			3'h2: return 32;
			3'h4: return 4;
			3'h5: return 16;
			3'h6: return 64;
			default: return 20;
		endcase
	endfunction

	// One full conversion: channel, reference, clock code and layout all follow the index
	task automatic run_conv(input logic [3:0] ch);
		logic [2:0] c;
		logic [9:0] r;
		logic [7:0] cw;
		// Divide by 2 outruns the comparator synchroniser; it is timed in the trigger scenario instead
		c = (ch[2:0] == ACC_CLK_DIV2) ? ACC_CLK_DIV4 : ch[2:0];
		cw = {ch[0], ch[1], ch, 2'h1};
		r = {ch, ch[1], 5'h15};
		axw(ACC_OFF_CLKCFG, {1'b0, c, 4'h0});
		axw(ACC_OFF_CTRL0, cw);
		repeat (20) @(posedge aclk);
		chk(32'(ch_sel), 32'(ch));
		chk(32'(ref_sel), 32'(ch[1]));
		busy_cyc = 0;
		axw(ACC_OFF_CTRL0, cw | 8'h02);
		rd_chk(ACC_OFF_CTRL0, 32'(cw | 8'h02));
		do axr(ACC_OFF_CTRL0, d); while (d[1] === 1'b1);
		chk(d, 32'(cw));
		chk(32'(busy_cyc), 32'(11 * divof(c)));
		rd_chk(ACC_OFF_RES_HI, ch[0] ? 32'(r[9:8]) : 32'(r[9:2]));
		rd_chk(ACC_OFF_RES_LO, ch[0] ? 32'(r[7:0]) : 32'({r[1:0], 6'h00}));
		chk(32'(irq), 32'h0000_0001);
		rd_chk(ACC_OFF_IRQ_ST, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, trig} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(ACC_OFF_CTRL0, 32'h0000_0000);
		rd_chk(ACC_OFF_CLKCFG, 32'h0000_0000);
		rd_chk(ACC_OFF_IRQ_ST, 32'h0000_0000);
		axw(ACC_OFF_CLKCFG, 8'hFF);
		chk(32'(last_resp), 32'(ACC_RESP_OKAY));
		rd_chk(ACC_OFF_CLKCFG, 32'h0000_0070);
		rd_chk(8'h18, 32'h0000_0000);
		chk(32'(last_resp), 32'(ACC_RESP_SLVERR));
		axw(8'h18, 8'h11);
		chk(32'(last_resp), 32'(ACC_RESP_SLVERR));
		// Results survive a second reset while control clears
		axw(ACC_OFF_CTRL0, 8'hC1);
		axw(ACC_OFF_RES_HI, 8'hA5);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(ACC_OFF_RES_HI, 32'h0000_00A5);
		rd_chk(ACC_OFF_CTRL0, 32'h0000_0000);
		chk(32'(pwr), 32'h0000_0000);
		axw(ACC_OFF_IRQ_MSK, 8'h01);
		// Go while unpowered must not start anything
		axw(ACC_OFF_CTRL0, 8'h02);
		repeat (30) @(posedge aclk);
		rd_chk(ACC_OFF_CTRL0, 32'h0000_0000);
		rd_chk(ACC_OFF_IRQ_ST, 32'h0000_0000);
		chk(32'(sample), 32'h0000_0000);
		// Codes 14 and 15 are reserved, so the sweep stops at 13
		for (int i = 0; i < 14; i++) run_conv(4'(i));
		// Abort in mid-conversion at the slowest divide
		axr(ACC_OFF_RES_HI, hi0);
		axr(ACC_OFF_RES_LO, lo0);
		axw(ACC_OFF_CLKCFG, 8'h60);
		axw(ACC_OFF_CTRL0, 8'h03);
		repeat (100) @(posedge aclk);
		axw(ACC_OFF_CTRL0, 8'h01);
		busy_cyc = 0;
		while (sample !== 1'b1) @(posedge aclk);
		chk(32'(busy_cyc >= 120 && busy_cyc <= 128), 32'h0000_0001);
		rd_chk(ACC_OFF_RES_HI, hi0);
		rd_chk(ACC_OFF_RES_LO, lo0);
		rd_chk(ACC_OFF_IRQ_ST, 32'h0000_0000);
		// Hardware start from the event trigger, also timing the divide by 2 setting
		axw(ACC_OFF_CLKCFG, 8'h00);
		busy_cyc = 0;
		trig <= 1'b1;
		@(posedge aclk);
		trig <= 1'b0;
		rd_chk(ACC_OFF_CTRL0, 32'h0000_0003);
		repeat (40) @(posedge aclk);
		rd_chk(ACC_OFF_CTRL0, 32'h0000_0001);
		rd_chk(ACC_OFF_IRQ_ST, 32'h0000_0001);
		chk(32'(busy_cyc), 32'(11 * divof(ACC_CLK_DIV2)));
		print_verdict();
	end
endmodule
